// ### core/pwm_timer_defines.svh
// Constants for the dual-slope 16-bit PWM timer: codes, limits, resets
`ifndef PWM_TIMER_DEFINES_SVH
`define PWM_TIMER_DEFINES_SVH

// Counter extremes and fixed resolutions
`define PWM_BOTTOM 16'h0000
`define PWM_TOP_8BIT 16'h00ff
`define PWM_TOP_9BIT 16'h01ff
`define PWM_TOP_10BIT 16'h03ff

// Waveform mode codes handled by this block
`define PWM_MODE_PC_8BIT 4'h1
`define PWM_MODE_PC_9BIT 4'h2
`define PWM_MODE_PC_10BIT 4'h3
`define PWM_MODE_PFC_CAPTURE 4'h8
`define PWM_MODE_PFC_CMP_A 4'h9
`define PWM_MODE_PC_CAPTURE 4'ha
`define PWM_MODE_PC_CMP_A 4'hb

// Output action field codes
`define PWM_ACT_OFF 2'h0
`define PWM_ACT_TOGGLE 2'h1
`define PWM_ACT_NONINV 2'h2
`define PWM_ACT_INV 2'h3

// Prescaler selections and their terminal counts (factor minus one)
`define PWM_CS_STOP 3'h0
`define PWM_CS_DIV1 3'h1
`define PWM_CS_DIV8 3'h2
`define PWM_CS_DIV64 3'h3
`define PWM_CS_DIV256 3'h4
`define PWM_CS_DIV1024 3'h5
`define PWM_TC_DIV1 10'h000
`define PWM_TC_DIV8 10'h007
`define PWM_TC_DIV64 10'h03f
`define PWM_TC_DIV256 10'h0ff
`define PWM_TC_DIV1024 10'h3ff

// Reset values
`define PWM_RST_COUNT 16'h0000
`define PWM_RST_COMPARE 16'h0000
`define PWM_RST_CAPTURE 16'h0000
`define PWM_RST_DIV 10'h000

`endif

// ### core/pwm_timer_pkg.sv
// Types shared by the dual-slope PWM timer files
package pwm_timer_pkg;

  // Count direction of the dual-slope counter
  typedef enum logic {count_up_state, count_down_state} count_dir_type;

  // Software configuration of the timer
  typedef struct packed {
    logic [3:0] waveform_mode_sel;
    logic [1:0] out_action_sel_a;
    logic [1:0] out_action_sel_b;
    logic [2:0] clock_select;
  } cfg_type;

  // Software writes, one strobe per register, shared data
  typedef struct packed {
    logic cmp_a_wr;
    logic cmp_b_wr;
    logic capture_wr;
    logic count_wr;
    logic [15:0] wdata;
  } wr_req_type;

  // Event flags; the same layout carries the clear strobes
  typedef struct packed {
    logic overflow_flag;
    logic capture_flag;
    logic compare_a_flag;
    logic compare_b_flag;
  } flags_type;

endpackage

// ### core/timer_prescaler.sv
// Prescaler making the timer clock enable from the system clock
`timescale 1ns/100ps
`include "pwm_timer_defines.svh"

module timer_prescaler
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] clock_select,
  output logic tick
);

  logic [9:0] div_reg; // Free-running divider count
  logic [9:0] term; // Terminal count for the selected factor
  logic running; // A factor is selected

  // Factor decode; unlisted codes stop the timer
  always_comb
  begin
    running = 1'b1;
    unique case (clock_select)
      `PWM_CS_DIV1: term = `PWM_TC_DIV1;
      `PWM_CS_DIV8: term = `PWM_TC_DIV8;
      `PWM_CS_DIV64: term = `PWM_TC_DIV64;
      `PWM_CS_DIV256: term = `PWM_TC_DIV256;
      `PWM_CS_DIV1024: term = `PWM_TC_DIV1024;
      default:
      begin
        term = `PWM_TC_DIV1;
        running = 1'b0;
      end
    endcase
  end

  // Divider restarts on terminal count; held at zero while stopped
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      div_reg <= `PWM_RST_DIV;
    else if (!running || div_reg >= term)
      div_reg <= `PWM_RST_DIV;
    else
      div_reg <= div_reg + 10'h001;
  end

  // One-cycle enable at each terminal count
  assign tick = running && (div_reg >= term);

endmodule

// ### core/compare_out_unit.sv
// One compare output: waveform level register and pin drive gating
`timescale 1ns/100ps
`include "pwm_timer_defines.svh"

module compare_out_unit
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic match,
  input wire logic match_rising,
  input wire logic [1:0] out_action_sel,
  input wire logic toggle_allowed,
  input wire logic pin_direction_bit,
  output logic compare_output,
  output logic pin_out,
  output logic pin_oe_n
);

  logic connected; // Output overrides the port pin

  // Toggle only where allowed, PWM codes always connect
  assign connected = (out_action_sel == `PWM_ACT_NONINV) ||
                     (out_action_sel == `PWM_ACT_INV) ||
                     ((out_action_sel == `PWM_ACT_TOGGLE) && toggle_allowed);

  // Level changes only on a match taken in a timer clock cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      compare_output <= 1'b0;
    else if (match)
    begin
      unique case (out_action_sel)
        `PWM_ACT_NONINV: compare_output <= !match_rising;
        `PWM_ACT_INV: compare_output <= match_rising;
        `PWM_ACT_TOGGLE:
        begin
          if (toggle_allowed)
            compare_output <= !compare_output;
        end
        `PWM_ACT_OFF: compare_output <= compare_output;
      endcase
    end
  end

  // Pin is driven only when connected and set as output
  assign pin_oe_n = !(connected && pin_direction_bit);
  assign pin_out = connected && pin_direction_bit && compare_output;

endmodule

// ### core/dual_slope_pwm_timer16.sv
// Dual-slope 16-bit PWM timer: counter, TOP, double buffers and flags
`timescale 1ns/100ps
`include "pwm_timer_defines.svh"

module dual_slope_pwm_timer16
#(
  parameter int CHANNELS = 2
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire pwm_timer_pkg::cfg_type cfg,
  input wire pwm_timer_pkg::wr_req_type wr,
  input wire pwm_timer_pkg::flags_type flag_clr,
  input wire logic pin_direction_bit_a,
  input wire logic pin_direction_bit_b,
  output logic [15:0] count_value,
  output logic count_falling,
  output logic [15:0] compare_a_value,
  output logic [15:0] compare_b_value,
  output logic [15:0] capture_value,
  output pwm_timer_pkg::flags_type flags,
  output logic compare_output_a,
  output logic compare_output_b,
  output logic pin_out_a,
  output logic pin_oe_n_a,
  output logic pin_out_b,
  output logic pin_oe_n_b
);

  // Timer clock enable from the prescaler
  logic tick;

  // Counter state
  logic [15:0] count_reg; // Present count
  pwm_timer_pkg::count_dir_type dir_reg; // Present slope
  logic [15:0] count_next; // Count after this tick

  // Capture register, written directly, never buffered
  logic [15:0] capture_reg;

  // Mode decode
  logic waveform_mode_hi_bit; // Top bit of the waveform mode
  logic pc_mode; // Phase correct family
  logic pfc_mode; // Phase and frequency correct family
  logic dual_mode; // Either dual-slope family
  logic fixed_top; // TOP is a fixed resolution
  logic top_is_capture; // Capture register is TOP
  logic top_is_cmp_a; // Active compare-A is TOP
  logic [15:0] top_value; // Selected TOP

  // Events sampled in a timer clock cycle
  logic at_top; // Count has just reached TOP on the way up
  logic at_bottom; // Count has just reached zero on the way down
  logic load_evt; // Buffered compare values go live
  logic [15:0] wdata_masked; // Write data after resolution mask

  // Per-channel compare state, exported from the generate loop
  logic [15:0] cmp_active [CHANNELS]; // Live compare values
  logic [CHANNELS-1:0] cmp_wr; // Write strobe per channel
  logic [CHANNELS-1:0] cmp_match; // Match taken this tick
  logic [CHANNELS-1:0] cmp_flag; // Sticky compare flags
  logic [CHANNELS-1:0] cmp_flag_clr; // Clear strobe per channel
  logic [CHANNELS-1:0] cmp_level; // Waveform level per channel
  logic [CHANNELS-1:0] pin_dir; // Direction bits per channel
  logic [CHANNELS-1:0] pin_drv; // Pin values per channel
  logic [CHANNELS-1:0] pin_oe; // Active-low enables per channel
  logic [1:0] action [CHANNELS]; // Output action per channel

  // Other sticky flags
  logic overflow_reg;
  logic capture_flag_reg;

  // Slope a match counts as; extremes are pinned to give flat levels
  logic match_rising;

  // Prescaler producing the timer clock enable
  timer_prescaler u_prescaler
  (
    .clk(clk),
    .arst_n(arst_n),
    .clock_select(cfg.clock_select),
    .tick(tick)
  );

  // Waveform mode decode into the two dual-slope families
  always_comb
  begin
    pc_mode = 1'b0;
    pfc_mode = 1'b0;
    fixed_top = 1'b0;
    top_is_capture = 1'b0;
    top_is_cmp_a = 1'b0;
    top_value = `PWM_TOP_8BIT;
    unique case (cfg.waveform_mode_sel)
      `PWM_MODE_PC_8BIT:
      begin
        pc_mode = 1'b1;
        fixed_top = 1'b1;
        top_value = `PWM_TOP_8BIT;
      end
      `PWM_MODE_PC_9BIT:
      begin
        pc_mode = 1'b1;
        fixed_top = 1'b1;
        top_value = `PWM_TOP_9BIT;
      end
      `PWM_MODE_PC_10BIT:
      begin
        pc_mode = 1'b1;
        fixed_top = 1'b1;
        top_value = `PWM_TOP_10BIT;
      end
      `PWM_MODE_PC_CAPTURE:
      begin
        pc_mode = 1'b1;
        top_is_capture = 1'b1;
        top_value = capture_reg;
      end
      `PWM_MODE_PC_CMP_A:
      begin
        pc_mode = 1'b1;
        top_is_cmp_a = 1'b1;
        top_value = cmp_active[0];
      end
      `PWM_MODE_PFC_CAPTURE:
      begin
        pfc_mode = 1'b1;
        top_is_capture = 1'b1;
        top_value = capture_reg;
      end
      `PWM_MODE_PFC_CMP_A:
      begin
        pfc_mode = 1'b1;
        top_is_cmp_a = 1'b1;
        top_value = cmp_active[0];
      end
      // Single-slope and plain counting modes are not built here
      default:
      begin
        top_value = `PWM_TOP_8BIT;
      end
    endcase
  end

  assign dual_mode = pc_mode || pfc_mode;
  assign waveform_mode_hi_bit = cfg.waveform_mode_sel[3];

  // Extremes are seen only on the slope that runs into them
  assign at_top = (dir_reg == pwm_timer_pkg::count_up_state) &&
                  (count_reg == top_value);
  assign at_bottom = (dir_reg == pwm_timer_pkg::count_down_state) &&
                     (count_reg == `PWM_BOTTOM);

  // Phase correct loads at TOP, frequency correct at zero
  assign load_evt = tick && ((pc_mode && at_top) ||
                             (pfc_mode && at_bottom));

  // Bits above a fixed resolution never reach the buffers
  assign wdata_masked = fixed_top ? (wr.wdata & top_value) : wr.wdata;

  // Next count: up to TOP, one tick there, then down to zero
  always_comb
  begin
    if (at_top)
      count_next = count_reg - 16'h0001;
    else if (at_bottom)
      count_next = count_reg + 16'h0001;
    else if (dir_reg == pwm_timer_pkg::count_up_state)
      count_next = count_reg + 16'h0001;
    else
      count_next = count_reg - 16'h0001;
  end

  // Counter; a software write takes precedence over a tick
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      count_reg <= `PWM_RST_COUNT;
    else if (wr.count_wr)
      count_reg <= wr.wdata;
    else if (tick && dual_mode)
      count_reg <= count_next;
  end

  // Slope reverses at each extreme, only on a tick
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      dir_reg <= pwm_timer_pkg::count_up_state;
    else if (tick && dual_mode && at_top)
      dir_reg <= pwm_timer_pkg::count_down_state;
    else if (tick && dual_mode && at_bottom)
      dir_reg <= pwm_timer_pkg::count_up_state;
  end

  // Capture register acts as TOP at once, so a low write can be
  // overrun; software must keep it at or above three
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      capture_reg <= `PWM_RST_CAPTURE;
    else if (wr.capture_wr)
      capture_reg <= wr.wdata;
  end

  // A match at zero belongs to the rising slope, one at TOP to the
  // falling slope; this gives flat outputs at the extremes
  always_comb
  begin
    if (count_reg == `PWM_BOTTOM)
      match_rising = 1'b1;
    else if (count_reg == top_value)
      match_rising = 1'b0;
    else
      match_rising = (dir_reg == pwm_timer_pkg::count_up_state);
  end

  // Channel strobe, clear and pin vectors
  assign cmp_wr = {wr.cmp_b_wr, wr.cmp_a_wr};
  assign cmp_flag_clr = {flag_clr.compare_b_flag, flag_clr.compare_a_flag};
  assign pin_dir = {pin_direction_bit_b, pin_direction_bit_a};
  assign action[0] = cfg.out_action_sel_a;
  assign action[1] = cfg.out_action_sel_b;

  // One compare channel per loop pass
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
      logic [15:0] buf_reg; // Software-visible buffered value
      logic [15:0] act_reg; // Value the comparator uses
      logic flag_reg; // Sticky match flag
      logic flag_set; // Flag event this cycle
      logic top_flag; // Compare-A doubles as the TOP flag

      // Buffer takes every write; a compare that exceeds TOP never
      // matches, which software must avoid
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          buf_reg <= `PWM_RST_COMPARE;
        else if (cmp_wr[ch])
          buf_reg <= wdata_masked;
      end

      // Double buffer: live value loads at the mode's update point
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          act_reg <= `PWM_RST_COMPARE;
        else if (!dual_mode)
          act_reg <= buf_reg;
        else if (load_evt)
          act_reg <= buf_reg;
      end

      assign cmp_active[ch] = act_reg;
      assign cmp_match[ch] = tick && dual_mode && (count_reg == act_reg);

      // Compare-A as TOP flags at TOP in both families
      assign top_flag = (ch == 0) && top_is_cmp_a && tick &&
                        ((pc_mode && load_evt) ||
                         (pfc_mode && at_top));
      assign flag_set = cmp_match[ch] || top_flag;

      // Set wins over a clear in the same cycle
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          flag_reg <= 1'b0;
        else if (flag_set)
          flag_reg <= 1'b1;
        else if (cmp_flag_clr[ch])
          flag_reg <= 1'b0;
      end

      assign cmp_flag[ch] = flag_reg;

      // Waveform and pin for this channel; toggle only on A
      compare_out_unit u_out
      (
        .clk(clk),
        .arst_n(arst_n),
        .match(cmp_match[ch]),
        .match_rising(match_rising),
        .out_action_sel(action[ch]),
        .toggle_allowed((ch == 0) && waveform_mode_hi_bit),
        .pin_direction_bit(pin_dir[ch]),
        .compare_output(cmp_level[ch]),
        .pin_out(pin_drv[ch]),
        .pin_oe_n(pin_oe[ch])
      );
    end
  endgenerate

  // Overflow flag at every zero in both families; set beats clear
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      overflow_reg <= 1'b0;
    else if (tick && dual_mode && at_bottom)
      overflow_reg <= 1'b1;
    else if (flag_clr.overflow_flag)
      overflow_reg <= 1'b0;
  end

  // Capture flag when the capture register is TOP; set beats clear
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      capture_flag_reg <= 1'b0;
    else if (top_is_capture && pc_mode && load_evt)
      capture_flag_reg <= 1'b1;
    else if (top_is_capture && pfc_mode && tick && at_top)
      capture_flag_reg <= 1'b1;
    else if (flag_clr.capture_flag)
      capture_flag_reg <= 1'b0;
  end

  // Status and readback, all from registers
  assign count_value = count_reg;
  assign count_falling = (dir_reg == pwm_timer_pkg::count_down_state);
  assign compare_a_value = g_chan[0].buf_reg;
  assign compare_b_value = g_chan[1].buf_reg;
  assign capture_value = capture_reg;
  assign flags.overflow_flag = overflow_reg;
  assign flags.capture_flag = capture_flag_reg;
  assign flags.compare_a_flag = cmp_flag[0];
  assign flags.compare_b_flag = cmp_flag[1];

  // Waveform levels and pins
  assign compare_output_a = cmp_level[0];
  assign compare_output_b = cmp_level[1];
  assign pin_out_a = pin_drv[0];
  assign pin_oe_n_a = pin_oe[0];
  assign pin_out_b = pin_drv[1];
  assign pin_oe_n_b = pin_oe[1];

endmodule

// ### tb/pwm_timer_assertions.sv
// Port checker for the dual-slope PWM timer
`timescale 1ns/100ps
`include "pwm_timer_defines.svh"

module pwm_timer_assertions
(
  input wire logic clk,
  input wire logic arst_n,
  input wire pwm_timer_pkg::cfg_type cfg,
  input wire pwm_timer_pkg::wr_req_type wr,
  input wire pwm_timer_pkg::flags_type flag_clr,
  input wire logic pin_direction_bit_a,
  input wire logic [15:0] count_value,
  input wire logic count_falling,
  input wire logic [15:0] compare_a_value,
  input wire pwm_timer_pkg::flags_type flags,
  input wire logic compare_output_a,
  input wire logic pin_out_a,
  input wire logic pin_oe_n_a,
  input wire logic pin_oe_n_b
);
  // Single domain; reset silences every check
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // Count moves one step unless software wrote it
  count_step_a: assert property (
    !$past(wr.count_wr) && $changed(count_value) |->
    count_value - $past(count_value) inside {16'h0001, 16'hffff})
    else $error("count jumped by more than one");
  // Turn down only after standing at the 8-bit fixed top
  fall_top_a: assert property (
    $rose(count_falling) && !$past(wr.count_wr) &&
    $past(cfg.waveform_mode_sel) == `PWM_MODE_PC_8BIT |->
    $past(count_value) == `PWM_TOP_8BIT)
    else $error("turned down away from top");
  // Turn up only from the bottom
  rise_bottom_a: assert property (
    $fell(count_falling) && !$past(wr.count_wr) |->
    $past(count_value) == `PWM_BOTTOM)
    else $error("turned up away from bottom");
  // Overflow only when the falling count hit zero
  overflow_zero_a: assert property (
    $rose(flags.overflow_flag) |->
    $past(count_value) == `PWM_BOTTOM && $past(count_falling))
    else $error("overflow away from bottom");
  // Compare-A flag is sticky until cleared
  flag_hold_a: assert property (
    flags.compare_a_flag && !flag_clr.compare_a_flag |=>
    flags.compare_a_flag)
    else $error("compare flag dropped");
  // 8-bit fixed top masks compare-A writes
  mask_8bit_a: assert property (
    wr.cmp_a_wr && cfg.waveform_mode_sel == `PWM_MODE_PC_8BIT |=>
    compare_a_value == ($past(wr.wdata) & `PWM_TOP_8BIT))
    else $error("compare write not masked");
  // Input direction keeps the pin released
  pin_off_a: assert property (
    !pin_direction_bit_a |-> pin_oe_n_a && !pin_out_a)
    else $error("pin driven while input");
  // Output direction with non-inverting action shows the waveform level
  pin_on_a: assert property (
    pin_direction_bit_a && cfg.out_action_sel_a == `PWM_ACT_NONINV |->
    !pin_oe_n_a && pin_out_a == compare_output_a)
    else $error("pin not following waveform");
  // Toggle action never connects channel B
  b_toggle_off_a: assert property (
    cfg.out_action_sel_b == `PWM_ACT_TOGGLE |-> pin_oe_n_b)
    else $error("channel B connected on toggle");

  // Main events seen
  cover property ($rose(flags.overflow_flag));
  cover property ($rose(count_falling));
  cover property ($rose(flags.capture_flag));
endmodule

bind dual_slope_pwm_timer16 pwm_timer_assertions pwm_timer_assertions_inst
(
  .clk(clk),
  .arst_n(arst_n),
  .cfg(cfg),
  .wr(wr),
  .flag_clr(flag_clr),
  .pin_direction_bit_a(pin_direction_bit_a),
  .count_value(count_value),
  .count_falling(count_falling),
  .compare_a_value(compare_a_value),
  .flags(flags),
  .compare_output_a(compare_output_a),
  .pin_out_a(pin_out_a),
  .pin_oe_n_a(pin_oe_n_a),
  .pin_oe_n_b(pin_oe_n_b)
);

// ### tb/tb_top.sv
// Self-checking bench for the dual-slope PWM timer
`timescale 1ns/100ps
`include "pwm_timer_defines.svh"

module tb_top;
  logic clk;
  logic arst_n;
  pwm_timer_pkg::cfg_type cfg;
  pwm_timer_pkg::wr_req_type wr;
  pwm_timer_pkg::flags_type flag_clr;
  logic dir_a;
  logic dir_b;
  logic [15:0] count_value;
  logic count_falling;
  logic [15:0] cmp_a;
  logic [15:0] cmp_b;
  logic [15:0] capture_value;
  pwm_timer_pkg::flags_type flags;
  logic out_a;
  logic out_b;
  logic pin_out_a;
  logic pin_oe_n_a;
  logic pin_out_b;
  logic pin_oe_n_b;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;

  dual_slope_pwm_timer16 dual_slope_pwm_timer16_inst
  (
    .clk(clk),
    .arst_n(arst_n),
    .cfg(cfg),
    .wr(wr),
    .flag_clr(flag_clr),
    .pin_direction_bit_a(dir_a),
    .pin_direction_bit_b(dir_b),
    .count_value(count_value),
    .count_falling(count_falling),
    .compare_a_value(cmp_a),
    .compare_b_value(cmp_b),
    .capture_value(capture_value),
    .flags(flags),
    .compare_output_a(out_a),
    .compare_output_b(out_b),
    .pin_out_a(pin_out_a),
    .pin_oe_n_a(pin_oe_n_a),
    .pin_out_b(pin_out_b),
    .pin_oe_n_b(pin_oe_n_b)
  );

  // 100 MHz clock
  always #5 clk = ~clk;

  // Hang guard, far above the longest expected run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_errors++;
      end_sim();
    end
  end

  // Verdict in one place
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Single compare; 1-bit values arrive zero extended
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write; strobes a,b,capture,count
  task automatic put(input logic [3:0] s, input logic [15:0] d);
    @(negedge clk);
    wr = {s, d};
    @(negedge clk);
    wr = '0;
  endtask

  // Stop, load top and zero count, then run; flags cleared on the way
  task automatic start(input logic [3:0] m, input logic [15:0] cap,
                       input logic [2:0] cs);
    cfg.clock_select = `PWM_CS_STOP;
    flag_clr = '1;
    put(4'h2, cap);
    put(4'h1, 16'h0000);
    flag_clr = '0;
    cfg.waveform_mode_sel = m;
    cfg.clock_select = cs;
  endtask

  // Bounded wait for a count value and slope
  task automatic wait_cnt(input logic [15:0] v, input logic f);
    int n;
    n = 0;
    while (!(count_value === v && count_falling === f) && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    chk(16'(n < 3000), 16'h0001);
  endtask

  // Clear overflow, count cycles until it sets again
  task automatic to_ovf(output int n);
    flag_clr.overflow_flag = 1'b1;
    @(negedge clk);
    flag_clr.overflow_flag = 1'b0;
    n = 1;
    while (flags.overflow_flag !== 1'b1 && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  // Stopped clock holds the counter at reset values
  task automatic t_stop;
    repeat (20) @(negedge clk);
    chk(count_value, 16'h0000);
    chk(16'(flags), 16'h0000);
    chk(pin_oe_n_a, 1'b1);
    $display("test stop done");
  endtask

  // Fixed tops mask compare writes, register top does not
  task automatic t_mask;
    for (int i = 1; i < 5; i++)
    begin
      cfg.waveform_mode_sel = (i == 4) ? `PWM_MODE_PC_CAPTURE : 4'(i);
      put(4'h4, 16'hffff);
      chk(cmp_b, (i == 4) ? 16'hffff : (16'h0001 << (i + 7)) - 1);
    end
    $display("test mask done");
  endtask

  // Period is twice factor times top; top register flags at top
  task automatic t_period;
    logic [3:0] m [5] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'ha};
    logic [15:0] cap [5] = '{16'h0, 16'h0, 16'h0, 16'h4, 16'h3};
    logic [2:0] cs [5] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h2};
    int p [5] = '{510, 1022, 2046, 8, 48};
    int n;
    for (int i = 0; i < 5; i++)
    begin
      start(m[i], cap[i], cs[i]);
      chk(capture_value, cap[i]);
      to_ovf(n);
      to_ovf(n);
      chk(16'(n), 16'(p[i]));
      chk(flags.capture_flag, m[i][3]);
    end
    $display("test period done");
  endtask

  // Turn at top, slope-dependent set and clear, compare flag
  task automatic t_wave;
    start(`PWM_MODE_PC_8BIT, 16'h0000, `PWM_CS_DIV1);
    cfg.out_action_sel_a = `PWM_ACT_NONINV;
    dir_a = 1'b1;
    put(4'h8, 16'h1202);
    chk(cmp_a, 16'h0002);
    wait_cnt(`PWM_TOP_8BIT, 1'b0);
    @(negedge clk);
    chk(count_value, 16'h00fe);
    chk(count_falling, 1'b1);
    wait_cnt(16'h0001, 1'b1);
    chk(out_a, 1'b1);
    chk(pin_out_a, 1'b1);
    flag_clr.compare_a_flag = 1'b1;
    @(negedge clk);
    flag_clr.compare_a_flag = 1'b0;
    wait_cnt(16'h0003, 1'b0);
    chk(out_a, 1'b0);
    chk(flags.compare_a_flag, 1'b1);
    dir_a = 1'b0;
    @(negedge clk);
    chk(pin_oe_n_a, 1'b1);
    $display("test wave done");
  endtask

  // Compare at bottom or top gives a constant level
  task automatic t_extreme;
    start(`PWM_MODE_PC_CAPTURE, 16'h0003, `PWM_CS_DIV1);
    dir_b = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      cfg.out_action_sel_b = i[1] ? `PWM_ACT_INV : `PWM_ACT_NONINV;
      put(4'h4, i[0] ? 16'h0003 : 16'h0000);
      repeat (20) @(negedge clk);
      for (int k = 0; k < 12; k++)
      begin
        chk(pin_out_b, 16'(i[1] ^ i[0]));
        chk(out_b, 16'(i[1] ^ i[0]));
        @(negedge clk);
      end
    end
    $display("test extreme done");
  endtask

  // Toggle on A with capture top, two matches per period
  task automatic t_toggle;
    int n;
    logic prev;
    cfg.out_action_sel_a = `PWM_ACT_TOGGLE;
    cfg.out_action_sel_b = `PWM_ACT_TOGGLE;
    dir_a = 1'b1;
    put(4'h8, 16'h0001);
    repeat (20) @(negedge clk);
    n = 0;
    prev = out_a;
    for (int k = 0; k < 24; k++)
    begin
      @(negedge clk);
      if (out_a !== prev)
        n++;
      prev = out_a;
    end
    chk(16'(n), 16'h0008);
    chk(pin_oe_n_a, 1'b0);
    chk(pin_oe_n_b, 1'b1);
    cfg.waveform_mode_sel = `PWM_MODE_PC_8BIT;
    @(negedge clk);
    chk(pin_oe_n_a, 1'b1);
    $display("test toggle done");
  endtask

  // Main sequence
  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    cfg = '0;
    wr = '0;
    flag_clr = '0;
    dir_a = 1'b0;
    dir_b = 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    t_stop();
    t_mask();
    t_period();
    t_wave();
    t_extreme();
    t_toggle();
    end_sim();
  end
endmodule
